// ===== logic/brs_sequencer.sv
// breaker reclose sequencer with voltage check selection and bus registers
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
module brs_sequencer #(
	parameter int VOLT_WIDTH = 8
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// reclose controls from scheme logic, breaker one
	input wire logic RECLOSE_ENABLE,
	input wire logic RECLOSE_START,
	input wire logic RECLOSE_INHIBIT,
	input wire logic RECLOSE_LOCKOUT,
	input wire logic RECLOSE_BLOCK,
	input wire logic SEQ_DISCONNECTORS_CLOSED,
	input wire logic IN_SYNCHRONISM,
	input wire logic FORCE_FAULTY,
	input wire logic TOKEN_DENIED,
	input wire logic BREAKER_OPEN,
	// voltage check controls, index 0 first breaker, 1 second
	input wire logic [1:0] LOCAL_VOLT_SEL0,
	input wire logic [1:0] LOCAL_VOLT_SEL1,
	input wire logic [1:0] REMOTE_VOLT_SEL0,
	input wire logic [1:0] REMOTE_VOLT_SEL1,
	input wire logic [1:0] SYNC_STAGE1_EN,
	input wire logic [1:0] SYNC_STAGE2_EN,
	input wire logic [1:0] SPLIT_DETECT_EN,
	input wire logic [1:0] STAGE1_COND,
	input wire logic [1:0] STAGE2_COND,
	// four analogue voltage magnitudes, packed
	input wire logic [4*VOLT_WIDTH-1:0] VOLT_IN,
	// sequencer outputs
	output logic BREAKER_FUNCTION_HEALTHY,
	output logic SEQUENCE_IN_PROGRESS,
	output logic CLOSURE_TOKEN_REQUEST,
	output logic BREAKER_CLOSE,
	output logic BREAKER_LOCKED_OUT,
	// voltage indications per breaker
	output logic [1:0] LOCAL_LIVE_IND,
	output logic [1:0] LOCAL_DEAD_IND,
	output logic [1:0] REMOTE_LIVE_IND,
	output logic [1:0] REMOTE_DEAD_IND,
	output logic [1:0] SYNC_STAGE1_MET,
	output logic [1:0] SYNC_STAGE2_MET,
	output logic [1:0] SPLIT_DETECTED,
	// interrupt
	output logic IRQ,
	// axi4-lite slave
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	import brs_pkg::*;

	// elaboration check: the level register holds at most 16 bits per field
	if (VOLT_WIDTH < 1 || VOLT_WIDTH > 16) begin : g_bad_width
		$error("VOLT_WIDTH must be 1 to 16");
	end

	// number of synchronised control inputs
	localparam int NSYNC = 10;
	// number of synchronised per-breaker fields (2 bits each)
	localparam int NPAIR = 9;

	// pick one of four voltages
	function automatic logic [VOLT_WIDTH-1:0] pick_volt(input logic [4*VOLT_WIDTH-1:0] v, input logic [1:0] s);
		pick_volt = v[s*VOLT_WIDTH +: VOLT_WIDTH];
	endfunction

	// two-flop synchronisers; first stage read only by second
	logic [NSYNC-1:0] raw_ctl;
	logic [NSYNC-1:0] meta_ctl;
	logic [NSYNC-1:0] ctl;
	logic [2*NPAIR-1:0] raw_pair;
	logic [2*NPAIR-1:0] meta_pair;
	logic [2*NPAIR-1:0] pair;
	logic [4*VOLT_WIDTH-1:0] meta_volt;
	logic [4*VOLT_WIDTH-1:0] volt;
	assign raw_ctl = {BREAKER_OPEN, TOKEN_DENIED, FORCE_FAULTY, IN_SYNCHRONISM,
		SEQ_DISCONNECTORS_CLOSED, RECLOSE_BLOCK, RECLOSE_LOCKOUT, RECLOSE_INHIBIT,
		RECLOSE_START, RECLOSE_ENABLE};
	assign raw_pair = {STAGE2_COND, STAGE1_COND, SPLIT_DETECT_EN, SYNC_STAGE2_EN, SYNC_STAGE1_EN,
		REMOTE_VOLT_SEL1, REMOTE_VOLT_SEL0, LOCAL_VOLT_SEL1, LOCAL_VOLT_SEL0};

	// sample every control, select and voltage pin on the tick
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			meta_ctl <= '0;
			ctl <= '0;
			meta_pair <= '0;
			pair <= '0;
			meta_volt <= '0;
			volt <= '0;
		end else begin
			meta_ctl <= raw_ctl;
			ctl <= meta_ctl;
			meta_pair <= raw_pair;
			pair <= meta_pair;
			meta_volt <= VOLT_IN;
			volt <= meta_volt;
		end
	end

	// named views of synchronised controls
	logic en, start, inhibit, lockout, block, disc, insync, faulty, denied, brk_open;
	assign {brk_open, denied, faulty, insync, disc, block, lockout, inhibit, start, en} = ctl;

	// software registers
	logic close_done_cmd; // one-cycle pulse from a control write
	logic [IRQ_WIDTH-1:0] irq_stat;
	logic [IRQ_WIDTH-1:0] irq_mask;
	logic [VOLT_WIDTH-1:0] live_level;
	logic [VOLT_WIDTH-1:0] dead_level;

	// sequencer state
	brs_state_type state;
	brs_state_type next_state;
	logic can_start;
	// a start is only accepted with every qualifier good
	assign can_start = en && !block && disc && !faulty;

	// next state logic
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (start && can_start) begin
					next_state = ST_ARMED;
				end
			end
			ST_ARMED: begin
				// hold at start until the start input is released
				if (!start) begin
					next_state = ST_DELAY;
				end
			end
			ST_DELAY: begin
				// inhibit delays; synchronism qualifies closure
				if (!inhibit && insync && !denied) begin
					next_state = ST_TOKEN;
				end
			end
			ST_TOKEN: begin
				// a late denial pulls the request back
				if (denied || inhibit) begin
					next_state = ST_DELAY;
				end else if (insync) begin
					next_state = ST_CLOSE;
				end
			end
			ST_CLOSE: begin
				// close is held until software reports completion
				if (close_done_cmd) begin
					next_state = ST_IDLE;
				end
			end
		endcase
		// lockout or a withdrawn enable cancels anything running
		if (lockout || !en) begin
			next_state = ST_IDLE;
		end
	end

	// state register
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// sequencer outputs, all registered
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			SEQUENCE_IN_PROGRESS <= 1'b0;
			CLOSURE_TOKEN_REQUEST <= 1'b0;
			BREAKER_CLOSE <= 1'b0;
			BREAKER_FUNCTION_HEALTHY <= 1'b0;
			BREAKER_LOCKED_OUT <= 1'b0;
		end else begin
			SEQUENCE_IN_PROGRESS <= (next_state != ST_IDLE);
			// withheld while denied even in the cycle it rises
			CLOSURE_TOKEN_REQUEST <= (next_state == ST_TOKEN) && !denied;
			BREAKER_CLOSE <= (next_state == ST_CLOSE) && !denied;
			BREAKER_FUNCTION_HEALTHY <= !faulty;
			BREAKER_LOCKED_OUT <= (next_state == ST_IDLE) && (brk_open || !can_start);
		end
	end

	// voltage checks per breaker, identical copies
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_brk
			logic [VOLT_WIDTH-1:0] vloc;
			logic [VOLT_WIDTH-1:0] vrem;
			// select fields sit in pairs of two bits
			assign vloc = pick_volt(volt, pair[2*g +: 2]);
			assign vrem = pick_volt(volt, pair[4+2*g +: 2]);
			always_ff @(posedge CLK or negedge RST_N) begin
				if (!RST_N) begin
					LOCAL_LIVE_IND[g] <= 1'b0;
					LOCAL_DEAD_IND[g] <= 1'b0;
					REMOTE_LIVE_IND[g] <= 1'b0;
					REMOTE_DEAD_IND[g] <= 1'b0;
					SYNC_STAGE1_MET[g] <= 1'b0;
					SYNC_STAGE2_MET[g] <= 1'b0;
					SPLIT_DETECTED[g] <= 1'b0;
				end else begin
					LOCAL_LIVE_IND[g] <= vloc > live_level;
					LOCAL_DEAD_IND[g] <= vloc < dead_level;
					REMOTE_LIVE_IND[g] <= vrem > live_level;
					REMOTE_DEAD_IND[g] <= vrem < dead_level;
					// a check only reports when switched on
					SYNC_STAGE1_MET[g] <= pair[8+g] && pair[14+g];
					SYNC_STAGE2_MET[g] <= pair[10+g] && pair[16+g];
					// split seen when both sides live but the stage2 condition is absent
					SPLIT_DETECTED[g] <= pair[12+g] && (vloc > live_level) && (vrem > live_level)
						&& !pair[16+g];
				end
			end
		end
	endgenerate

	// events for the interrupt status
	logic [IRQ_WIDTH-1:0] events;
	logic faulty_q;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			faulty_q <= 1'b0;
		end else begin
			faulty_q <= faulty;
		end
	end
	always_comb begin
		events = '0;
		events[IRQ_START] = (state == ST_IDLE) && (next_state == ST_ARMED);
		events[IRQ_CANCEL] = (state != ST_IDLE) && (state != ST_CLOSE) && (next_state == ST_IDLE);
		events[IRQ_CLOSED] = (state == ST_CLOSE) && (next_state == ST_IDLE);
		events[IRQ_FAULTY] = faulty && !faulty_q;
	end

	// axi write channel: take address and data in either order
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	assign do_write = aw_held && w_held && !S_AXI_BVALID;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= 2'b00;
		end else begin
			S_AXI_AWREADY <= !aw_held && !(S_AXI_AWVALID && S_AXI_AWREADY);
			S_AXI_WREADY <= !w_held && !(S_AXI_WVALID && S_AXI_WREADY);
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				// unmapped addresses answer slverr
				S_AXI_BRESP <= (aw_addr == OFS_CTRL || aw_addr == OFS_IRQ_STAT || aw_addr == OFS_IRQ_MASK
					|| aw_addr == OFS_LEVEL || aw_addr == OFS_STAT || aw_addr == OFS_VSEL) ? 2'b00 : 2'b10;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// register writes; status sets win over write-one clears
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			close_done_cmd <= 1'b0;
			irq_stat <= '0;
			irq_mask <= RESET_MASK[IRQ_WIDTH-1:0];
			live_level <= RESET_LIVE_LEVEL[VOLT_WIDTH-1:0];
			dead_level <= RESET_DEAD_LEVEL[VOLT_WIDTH-1:0];
		end else begin
			close_done_cmd <= do_write && aw_addr == OFS_CTRL && w_strb[0] && w_data[CTRL_CLOSE_DONE];
			if (do_write && aw_addr == OFS_IRQ_STAT && w_strb[0]) begin
				irq_stat <= (irq_stat & ~w_data[IRQ_WIDTH-1:0]) | events;
			end else begin
				irq_stat <= irq_stat | events;
			end
			if (do_write && aw_addr == OFS_IRQ_MASK && w_strb[0]) begin
				irq_mask <= w_data[IRQ_WIDTH-1:0];
			end
			if (do_write && aw_addr == OFS_LEVEL) begin
				if (w_strb[0]) begin
					live_level <= w_data[VOLT_WIDTH-1:0];
				end
				if (w_strb[2]) begin
					dead_level <= w_data[16 +: VOLT_WIDTH];
				end
			end
		end
	end

	// interrupt output, high while any unmasked status bit is set
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(irq_stat & irq_mask);
		end
	end

	// read data mux
	logic [31:0] rd_word;
	logic rd_ok;
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		unique case (S_AXI_ARADDR)
			OFS_CTRL: rd_word = 32'h0000_0000;
			OFS_STAT: begin
				rd_word[STAT_HEALTHY] = BREAKER_FUNCTION_HEALTHY;
				rd_word[STAT_IN_PROG] = SEQUENCE_IN_PROGRESS;
				rd_word[STAT_TOKEN_REQ] = CLOSURE_TOKEN_REQUEST;
				rd_word[STAT_LOCKED] = BREAKER_LOCKED_OUT;
				rd_word[STAT_CLOSE] = BREAKER_CLOSE;
				rd_word[STAT_STATE +: 3] = state;
			end
			OFS_IRQ_STAT: rd_word[IRQ_WIDTH-1:0] = irq_stat;
			OFS_IRQ_MASK: rd_word[IRQ_WIDTH-1:0] = irq_mask;
			OFS_VSEL: rd_word[15:0] = {LOCAL_LIVE_IND, LOCAL_DEAD_IND, REMOTE_LIVE_IND, REMOTE_DEAD_IND,
				SYNC_STAGE1_MET, SYNC_STAGE2_MET, SPLIT_DETECTED, 2'b00};
			OFS_LEVEL: begin
				rd_word[VOLT_WIDTH-1:0] = live_level;
				rd_word[16 +: VOLT_WIDTH] = dead_level;
			end
			default: rd_ok = 1'b0;
		endcase
	end

	// axi read channel, answer one cycle after address taken
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= 2'b00;
		end else begin
			S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_word;
				S_AXI_RRESP <= rd_ok ? 2'b00 : 2'b10;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

endmodule

// ===== logic/brs_pkg.sv
// package of constants for the breaker reclose sequencer
package brs_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFS_VSEL = 8'h10;
	localparam logic [7:0] OFS_LEVEL = 8'h14;
	// control register fields
	localparam int CTRL_CLOSE_DONE = 0;
	// status register fields
	localparam int STAT_HEALTHY = 0;
	localparam int STAT_IN_PROG = 1;
	localparam int STAT_TOKEN_REQ = 2;
	localparam int STAT_LOCKED = 3;
	localparam int STAT_CLOSE = 4;
	localparam int STAT_STATE = 8;
	// interrupt bits
	localparam int IRQ_START = 0;
	localparam int IRQ_CANCEL = 1;
	localparam int IRQ_CLOSED = 2;
	localparam int IRQ_FAULTY = 3;
	localparam int IRQ_WIDTH = 4;
	// reset values
	localparam logic [31:0] RESET_MASK = 32'h0000_0000;
	localparam logic [7:0] RESET_LIVE_LEVEL = 8'hC0;
	localparam logic [7:0] RESET_DEAD_LEVEL = 8'h20;
	// sequencer states, gray along start, wait, token, close
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ARMED = 3'b001,
		ST_DELAY = 3'b011,
		ST_TOKEN = 3'b010,
		ST_CLOSE = 3'b110
	} brs_state_type;
endpackage

// ===== tb/brs_sequencer_asserts.sv
// port-level checker for the breaker reclose sequencer
module brs_sequencer_asserts (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// scheme logic levels
	input wire logic RECLOSE_ENABLE,
	input wire logic RECLOSE_INHIBIT,
	input wire logic RECLOSE_LOCKOUT,
	input wire logic RECLOSE_BLOCK,
	input wire logic IN_SYNCHRONISM,
	input wire logic FORCE_FAULTY,
	input wire logic TOKEN_DENIED,
	// sequencer outputs
	input wire logic BREAKER_FUNCTION_HEALTHY,
	input wire logic SEQUENCE_IN_PROGRESS,
	input wire logic CLOSURE_TOKEN_REQUEST,
	input wire logic BREAKER_CLOSE,
	input wire logic BREAKER_LOCKED_OUT,
	input wire logic IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dcb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	// inputs pass two sync flops, so causes are looked for three or four samples back
	property p_fault_unhealthy;
		FORCE_FAULTY [*4] |-> !BREAKER_FUNCTION_HEALTHY;
	endproperty
	a_fault_unhealthy: assert property (p_fault_unhealthy) else $error("healthy while faulty held");
	property p_start_enabled;
		$rose(SEQUENCE_IN_PROGRESS) |-> $past(RECLOSE_ENABLE, 3) || $past(RECLOSE_ENABLE, 4);
	endproperty
	a_start_enabled: assert property (p_start_enabled) else $error("start while disabled");
	property p_start_unblocked;
		$rose(SEQUENCE_IN_PROGRESS) |-> !$past(RECLOSE_BLOCK, 3) || !$past(RECLOSE_BLOCK, 4);
	endproperty
	a_start_unblocked: assert property (p_start_unblocked) else $error("start while blocked");
	property p_lockout_cancels;
		RECLOSE_LOCKOUT [*6] |-> !SEQUENCE_IN_PROGRESS;
	endproperty
	a_lockout_cancels: assert property (p_lockout_cancels) else $error("sequence survives lockout");
	property p_inhibit_holds;
		RECLOSE_INHIBIT [*5] |-> !CLOSURE_TOKEN_REQUEST;
	endproperty
	a_inhibit_holds: assert property (p_inhibit_holds) else $error("token while inhibited");
	property p_denied_holds;
		TOKEN_DENIED [*5] |-> !CLOSURE_TOKEN_REQUEST && !BREAKER_CLOSE;
	endproperty
	a_denied_holds: assert property (p_denied_holds) else $error("token or close while denied");
	property p_token_first;
		$rose(BREAKER_CLOSE) |-> $past(CLOSURE_TOKEN_REQUEST);
	endproperty
	a_token_first: assert property (p_token_first) else $error("close without token");
	property p_token_in_sync;
		$rose(CLOSURE_TOKEN_REQUEST) |-> $past(IN_SYNCHRONISM, 3) || $past(IN_SYNCHRONISM, 4);
	endproperty
	a_token_in_sync: assert property (p_token_in_sync) else $error("token out of sync");
	property p_locked_idle;
		BREAKER_LOCKED_OUT |-> !SEQUENCE_IN_PROGRESS;
	endproperty
	a_locked_idle: assert property (p_locked_idle) else $error("locked out while running");
	property p_disabled_locked;
		!RECLOSE_ENABLE [*4] |-> BREAKER_LOCKED_OUT;
	endproperty
	a_disabled_locked: assert property (p_disabled_locked) else $error("not locked out while disabled");
	// main scenarios reached
	c_close: cover property ($rose(BREAKER_CLOSE));
	c_end: cover property ($fell(SEQUENCE_IN_PROGRESS));
	c_irq: cover property ($rose(IRQ));
endmodule
bind brs_sequencer brs_sequencer_asserts brs_sequencer_asserts_inst (.*);

// ===== tb/brs_scheme_model.sv
// scheme logic model: start pulses and token arbitration
module brs_scheme_model (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// bench commands
	input wire logic fire_start,
	input wire logic slow,
	input wire logic deny_req,
	// levels toward the sequencer
	output logic RECLOSE_START,
	output logic TOKEN_DENIED
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] hold; // cycles left with start held
	// start is held a while, then always released, since the sequence waits for it
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			RECLOSE_START <= 1'h0;
			hold <= 4'h0;
		end else if (fire_start && !RECLOSE_START) begin
			RECLOSE_START <= 1'h1;
			hold <= slow ? 4'h8 : 4'h2;
		end else if (hold != 4'h0) begin
			hold <= hold - 4'h1;
		end else begin
			RECLOSE_START <= 1'h0;
		end
	end
	// arbitration answer one cycle after the bench asks
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) TOKEN_DENIED <= 1'h0;
		else TOKEN_DENIED <= deny_req;
	end
endmodule

// ===== tb/tb_breaker_reclose_sequencer.sv
// self-checking bench for the breaker reclose sequencer
module tb_breaker_reclose_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import brs_pkg::*;
	// clock, reset, scheme logic levels (port names kept for implicit hookup)
	logic CLK = 1'h0, RST_N = 1'h0, fire_start = 1'h0, slow = 1'h0, deny_req = 1'h0;
	logic RECLOSE_ENABLE = 1'h0, RECLOSE_INHIBIT = 1'h0, RECLOSE_LOCKOUT = 1'h0, RECLOSE_BLOCK = 1'h0;
	logic SEQ_DISCONNECTORS_CLOSED = 1'h0, IN_SYNCHRONISM = 1'h0, FORCE_FAULTY = 1'h0, BREAKER_OPEN = 1'h0;
	logic RECLOSE_START, TOKEN_DENIED;
	logic [1:0] LOCAL_VOLT_SEL0 = '0, LOCAL_VOLT_SEL1 = '0, REMOTE_VOLT_SEL0 = '0, REMOTE_VOLT_SEL1 = '0;
	logic [1:0] SYNC_STAGE1_EN = '0, SYNC_STAGE2_EN = '0, SPLIT_DETECT_EN = '0, STAGE1_COND = '0, STAGE2_COND = '0;
	logic [31:0] VOLT_IN = '0;
	// outputs
	logic BREAKER_FUNCTION_HEALTHY, SEQUENCE_IN_PROGRESS, CLOSURE_TOKEN_REQUEST, BREAKER_CLOSE;
	logic BREAKER_LOCKED_OUT, IRQ;
	logic [1:0] LOCAL_LIVE_IND, LOCAL_DEAD_IND, REMOTE_LIVE_IND, REMOTE_DEAD_IND;
	logic [1:0] SYNC_STAGE1_MET, SYNC_STAGE2_MET, SPLIT_DETECTED;
	// register bus
	logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
	logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0, S_AXI_ARVALID = 1'h0;
	logic S_AXI_RREADY = 1'h0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	// bookkeeping
	int n_errors = 0, num_checks = 0;
	logic [67:0] exp_q[$]; // mask and value for each read still owed
	logic [67:0] exp_e;
	logic [31:0] seed = 32'he9bf_6606;
	logic tok_seen = 1'h0; // token request seen high at least once
	brs_sequencer #(.VOLT_WIDTH(8)) brs_sequencer_inst (.*);
	brs_scheme_model brs_scheme_model_inst (.*);
	always #20 CLK = ~CLK;
	// the token request stands one cycle before close, so it is latched here
	always @(posedge CLK) if (CLOSURE_TOKEN_REQUEST) tok_seen <= 1'h1;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// expected live/dead flags of one breaker for the chosen inputs
	function automatic logic [33:0] vind(input logic [31:0] v, input logic [1:0] l, r);
		logic [7:0] a, b;
		a = v[8*l+:8];
		b = v[8*r+:8];
		return {30'h0, a > RESET_LIVE_LEVEL, a < RESET_DEAD_LEVEL, b > RESET_LIVE_LEVEL, b < RESET_DEAD_LEVEL};
	endfunction
	task automatic check(input logic [33:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (n_errors == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge CLK);
	endtask
	task automatic fire();
		fire_start <= 1'h1;
		@(posedge CLK);
		fire_start <= 1'h0;
	endtask
	// one write; address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		do begin
			@(posedge CLK);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
		end while ((S_AXI_AWVALID && !S_AXI_AWREADY) || (S_AXI_WVALID && !S_AXI_WREADY));
		while (!S_AXI_BVALID) @(posedge CLK);
		check({32'h0, S_AXI_BRESP}, {32'h0, r});
		S_AXI_BREADY <= 1'h0;
	endtask
	// one read; the answer is judged by the watcher below
	task automatic rd(input logic [7:0] a, input logic [33:0] m, e);
		@(posedge CLK);
		exp_q.push_back({m, e});
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		do @(posedge CLK); while (!S_AXI_ARREADY);
		S_AXI_ARVALID <= 1'h0;
		do @(posedge CLK); while (!S_AXI_RVALID);
		S_AXI_RREADY <= 1'h0;
	endtask
	// read answers compared in arrival order
	always @(posedge CLK) begin
		if (S_AXI_RVALID && S_AXI_RREADY) begin
			exp_e = exp_q.pop_front();
			check({S_AXI_RRESP, S_AXI_RDATA} & exp_e[67:34], exp_e[33:0]);
		end
	end
	// hang guard, far beyond the expected run
	initial begin
		#200000;
		n_errors++;
		tally_and_finish();
	end
	initial begin
		logic [1:0] s;
		logic [31:0] v;
		logic [33:0] e0, e1;
		repeat (5) @(posedge CLK);
		check(SEQUENCE_IN_PROGRESS, 0);
		RST_N <= 1'h1;
		RECLOSE_ENABLE <= 1'h1;
		SEQ_DISCONNECTORS_CLOSED <= 1'h1;
		wt(6);
		check(BREAKER_FUNCTION_HEALTHY, 1);
		rd(OFS_LEVEL, 34'h3_00FF_00FF, {10'h0, RESET_DEAD_LEVEL, 8'h00, RESET_LIVE_LEVEL});
		rd(OFS_IRQ_MASK, 34'h3_0000_000F, 34'h0);
		rd(8'hFC, 34'h3_0000_0000, 34'h2_0000_0000);
		wr(8'hF8, 32'h0000_0001, 2'h2);
		wr(OFS_IRQ_MASK, 32'h0000_0001, 2'h0);
		rd(OFS_IRQ_MASK, 34'h3_0000_000F, 34'h1);
		// every refused start: blocked, disconnectors open, faulty, disabled with breaker open
		for (int i = 0; i < 4; i++) begin
			RECLOSE_BLOCK <= (i == 0);
			SEQ_DISCONNECTORS_CLOSED <= (i != 1);
			FORCE_FAULTY <= (i == 2);
			RECLOSE_ENABLE <= (i != 3);
			BREAKER_OPEN <= (i == 3);
			wt(5);
			fire();
			wt(12);
			check(SEQUENCE_IN_PROGRESS, 0);
			check(BREAKER_LOCKED_OUT, 1);
			check(BREAKER_FUNCTION_HEALTHY, i != 2);
		end
		RECLOSE_BLOCK <= 1'h0;
		SEQ_DISCONNECTORS_CLOSED <= 1'h1;
		RECLOSE_ENABLE <= 1'h1;
		BREAKER_OPEN <= 1'h0;
		RECLOSE_INHIBIT <= 1'h1;
		deny_req <= 1'h1;
		slow <= 1'h1;
		wt(5);
		check(BREAKER_LOCKED_OUT, 0);
		fire();
		wt(8);
		check(SEQUENCE_IN_PROGRESS, 1);
		check(IRQ, 1);
		// start still held, so the sequence must still sit at its start
		rd(OFS_STAT, 34'h3_0000_071F, {23'h0, ST_ARMED, 8'h03});
		RECLOSE_BLOCK <= 1'h1;
		SEQ_DISCONNECTORS_CLOSED <= 1'h0;
		wt(20);
		check(CLOSURE_TOKEN_REQUEST, 0);
		RECLOSE_INHIBIT <= 1'h0;
		wt(10);
		check(CLOSURE_TOKEN_REQUEST, 0);
		deny_req <= 1'h0;
		wt(10);
		check(CLOSURE_TOKEN_REQUEST, 0);
		check(SEQUENCE_IN_PROGRESS, 1);
		IN_SYNCHRONISM <= 1'h1;
		wt(10);
		check(BREAKER_CLOSE, 1);
		check(tok_seen, 1);
		wr(OFS_CTRL, 32'h0000_0001, 2'h0);
		wt(5);
		check(SEQUENCE_IN_PROGRESS, 0);
		wr(OFS_IRQ_STAT, 32'h0000_000F, 2'h0);
		wt(3);
		check(IRQ, 0);
		RECLOSE_BLOCK <= 1'h0;
		SEQ_DISCONNECTORS_CLOSED <= 1'h1;
		slow <= 1'h0;
		wt(5);
		fire();
		wt(5);
		check(SEQUENCE_IN_PROGRESS, 1);
		RECLOSE_LOCKOUT <= 1'h1;
		wt(8);
		check(SEQUENCE_IN_PROGRESS, 0);
		RECLOSE_LOCKOUT <= 1'h0;
		// every start qualifier good, only the open breaker locks out
		BREAKER_OPEN <= 1'h1;
		wt(5);
		check(BREAKER_LOCKED_OUT, 1);
		// random voltages against every select code, both breakers
		for (int k = 0; k < 4; k++) begin
			s = k[1:0];
			seed = xs(seed);
			// last pass: every voltage live, split check on, stage two off
			if (k == 3) seed[9:6] = 4'b1100;
			v = (k == 3) ? (seed | 32'hE0E0_E0E0) : seed;
			e0 = vind(v, s, ~s);
			e1 = vind(v, s + 2'h1, s + 2'h2);
			VOLT_IN <= v;
			LOCAL_VOLT_SEL0 <= s;
			REMOTE_VOLT_SEL0 <= ~s;
			LOCAL_VOLT_SEL1 <= s + 2'h1;
			REMOTE_VOLT_SEL1 <= s + 2'h2;
			SYNC_STAGE1_EN <= seed[1:0];
			STAGE1_COND <= seed[3:2];
			SYNC_STAGE2_EN <= seed[5:4];
			STAGE2_COND <= seed[7:6];
			SPLIT_DETECT_EN <= seed[9:8];
			wt(6);
			check({LOCAL_LIVE_IND[0], LOCAL_DEAD_IND[0], REMOTE_LIVE_IND[0], REMOTE_DEAD_IND[0]}, e0);
			check({LOCAL_LIVE_IND[1], LOCAL_DEAD_IND[1], REMOTE_LIVE_IND[1], REMOTE_DEAD_IND[1]}, e1);
			check(SPLIT_DETECTED, {seed[9] & e1[3] & e1[1] & ~seed[7], seed[8] & e0[3] & e0[1] & ~seed[6]});
			check({SYNC_STAGE1_MET, SYNC_STAGE2_MET}, {seed[1:0] & seed[3:2], seed[5:4] & seed[7:6]});
		end
		tally_and_finish();
	end
endmodule
